// *** rtl/atd_consts.svh ***
`ifndef ATD_CONSTS_SVH
`define ATD_CONSTS_SVH

// ----------------------------------------------------------------
// Result layouts
// ----------------------------------------------------------------
`define ATD_LAYOUT_INT      2'b00
`define ATD_LAYOUT_SINT     2'b01
`define ATD_LAYOUT_FRAC     2'b10
`define ATD_LAYOUT_SFRAC    2'b11

// ----------------------------------------------------------------
// Compare types
// ----------------------------------------------------------------
`define ATD_CMP_LESS        2'b00
`define ATD_CMP_GREATER     2'b01
`define ATD_CMP_INSIDE      2'b10
`define ATD_CMP_OUTSIDE     2'b11

// ----------------------------------------------------------------
// Write dispositions
// ----------------------------------------------------------------
`define ATD_WR_LEGACY       2'b00
`define ATD_WR_CMP_STORE    2'b01
`define ATD_WR_CMP_DISCARD  2'b10

// ----------------------------------------------------------------
// Sizes and defaults
// ----------------------------------------------------------------
`define ATD_WORD_W          16
`define ATD_CODE_W          12
`define ATD_NUM_CHAN        16
`define ATD_MIRROR_OFS      9
`define ATD_TRIG_W          16

`endif

// *** rtl/atd_pkg.sv ***
package atd_pkg;

  typedef logic [15:0] atd_word_t;

  typedef enum logic [2:0] {
    ATD_IDLE,
    ATD_ARMED,
    ATD_START,
    ATD_WAIT,
    ATD_EVAL
  } atd_state_e;

endpackage : atd_pkg

// *** rtl/atd_formatter.sv ***
`timescale 1ns/1ps
`include "atd_consts.svh"

module atd_formatter (
  // Conversion code
  input  wire logic [11:0]       i_code,
  input  wire logic              i_ten_bit,
  input  wire logic [1:0]        i_layout,
  // Packed result
  output atd_pkg::atd_word_t     o_word
);

  logic [9:0] code10;

  assign code10 = i_code[9:0];

  // Signed layouts flip the top code bit: code minus midscale
  always_comb begin
    if (i_ten_bit) begin
      unique case (i_layout)
        `ATD_LAYOUT_INT:   o_word = {6'h00, code10};
        `ATD_LAYOUT_SINT:  o_word = {{7{~code10[9]}}, code10[8:0]};
        `ATD_LAYOUT_FRAC:  o_word = {code10, 6'h00};
        `ATD_LAYOUT_SFRAC: o_word = {~code10[9], code10[8:0], 6'h00};
      endcase
    end else begin
      unique case (i_layout)
        `ATD_LAYOUT_INT:   o_word = {4'h0, i_code};
        `ATD_LAYOUT_SINT:  o_word = {{5{~i_code[11]}}, i_code[10:0]};
        `ATD_LAYOUT_FRAC:  o_word = {i_code, 4'h0};
        `ATD_LAYOUT_SFRAC: o_word = {~i_code[11], i_code[10:0], 4'h0};
      endcase
    end
  end

endmodule : atd_formatter

// *** rtl/atd_comparator.sv ***
`timescale 1ns/1ps
`include "atd_consts.svh"

module atd_comparator (
  // Operands
  input  wire atd_pkg::atd_word_t i_value,
  input  wire atd_pkg::atd_word_t i_thr_lo,
  input  wire atd_pkg::atd_word_t i_thr_hi,
  // Mode
  input  wire logic [1:0]         i_cmp_type,
  input  wire logic               i_signed,
  // Result
  output logic                    o_hit
);

  logic gt_lo;
  logic lt_lo;
  logic lt_hi;
  logic gt_hi;

  // Signed layouts compare as two's complement, others as unsigned
  always_comb begin
    if (i_signed) begin
      gt_lo = $signed(i_value) > $signed(i_thr_lo);
      lt_lo = $signed(i_value) < $signed(i_thr_lo);
      lt_hi = $signed(i_value) < $signed(i_thr_hi);
      gt_hi = $signed(i_value) > $signed(i_thr_hi);
    end else begin
      gt_lo = i_value > i_thr_lo;
      lt_lo = i_value < i_thr_lo;
      lt_hi = i_value < i_thr_hi;
      gt_hi = i_value > i_thr_hi;
    end
  end

  always_comb begin
    unique case (i_cmp_type)
      `ATD_CMP_LESS:    o_hit = lt_lo;
      `ATD_CMP_GREATER: o_hit = gt_lo;
      `ATD_CMP_INSIDE:  o_hit = gt_lo && lt_hi;
      `ATD_CMP_OUTSIDE: o_hit = lt_lo || gt_hi;
    endcase
  end

endmodule : atd_comparator

// *** rtl/atd_top.sv ***
// Operation
// - 12-bit fractional: code in bits 15..4; signed flips top code bit.
// - 10-bit integer right-justified, fractional left-justified, zero filled.
// - 10-bit signed integer equals code minus 512, sign extended.
// - 10-bit signed fractional equals code minus 512, left-justified.
// - Threshold comparison acts only while the detect enable is set.
// - Each set scan-select bit adds its channel to the scan.
// - Scan enable plus detect enable arm a scan started by trigger; the code arms on scan enable with any scan-select bit set.
// - Legacy scanning follows scan enable alone, without comparison.
// - Comparisons run in low power; a raised interrupt wakes the core.
// - With low-power enable, return to low power after servicing.
// - Compare type picks greater, less, inside or outside window.
// - Write disposition picks discard, compare-store or plain store.
// - Storing dispositions use split and channel-indexed bits for address.
// - Disposition 01 is compare-and-store; FIFO may clobber thresholds.
// - Result buffer is software readable and writable, holds thresholds.
// - Channel matches are recorded in sticky compare-hit bits.
// - Repeatedly scan the sequence, evaluate matches, raise interrupt.
// - Type 01 tests greater than threshold, 00 less than.
// - Type 10 matches strictly between lower and mirrored upper.
// - Disposition 10 discards the conversion, threshold kept.
// - Two-bit layout field picks one of four 16-bit layouts.
`timescale 1ns/1ps
`include "atd_consts.svh"

module atd_top #(
  parameter int NCH        = `ATD_NUM_CHAN,
  parameter int MIRROR_OFS = `ATD_MIRROR_OFS,
  parameter int TRIG_W     = `ATD_TRIG_W
) (
  // Clock and reset
  input  wire logic                  i_clk_sys,
  input  wire logic                  i_rst_n,
  // Configuration
  input  wire logic                  i_threshold_detect_enable,
  input  wire logic                  i_scan_enable_bit,
  input  wire logic [3:0]            i_trigger_source_select,
  input  wire logic                  i_low_power_threshold_enable,
  input  wire logic [1:0]            i_compare_type_field,
  input  wire logic [1:0]            i_write_disposition_field,
  input  wire logic                  i_split_buffer_bit,
  input  wire logic                  i_channel_indexed_bit,
  input  wire logic [1:0]            i_result_layout_select,
  input  wire logic                  i_ten_bit_mode,
  input  wire logic [NCH-1:0]        i_scan_select,
  // Trigger sources
  input  wire logic [TRIG_W-1:0]     i_trigger,
  // Converter core
  output logic                       o_conv_start,
  output logic [$clog2(NCH)-1:0]     o_conv_chan,
  input  wire logic                  i_conv_done,
  input  wire logic [11:0]           i_conv_code,
  // Buffer access
  input  wire logic                  i_buf_wr,
  input  wire logic                  i_buf_rd,
  input  wire logic [$clog2(NCH)-1:0] i_buf_addr,
  input  wire atd_pkg::atd_word_t    i_buf_wdata,
  output atd_pkg::atd_word_t         o_buf_rdata,
  // Compare hits
  input  wire logic [NCH-1:0]        i_hit_clear,
  output logic [NCH-1:0]             o_compare_hit,
  // Events and power
  output logic                       o_match_pulse,
  output logic                       o_scan_done,
  input  wire logic                  i_core_asleep,
  input  wire logic                  i_int_serviced,
  output logic                       o_wake_request,
  output logic                       o_sleep_return
);

  localparam int CW = $clog2(NCH);
  localparam int HALF = NCH / 2;

  // ----------------------------------------------------------------
  // Channel walk helpers
  // ----------------------------------------------------------------
  function automatic logic [CW-1:0] next_sel(input logic [NCH-1:0] sel,
                                             input logic [CW-1:0]  cur);
    logic [CW-1:0] res;
    int            idx;
    res = cur;
    for (int k = NCH; k >= 1; k--) begin
      idx = (int'(cur) + k) % NCH;
      if (sel[idx]) begin
        res = CW'(idx);
      end
    end
    return res;
  endfunction : next_sel

  function automatic logic [CW-1:0] last_sel(input logic [NCH-1:0] sel);
    logic [CW-1:0] res;
    res = '0;
    for (int k = 0; k < NCH; k++) begin
      if (sel[k]) begin
        res = CW'(k);
      end
    end
    return res;
  endfunction : last_sel

  // ----------------------------------------------------------------
  // State and storage
  // ----------------------------------------------------------------
  atd_pkg::atd_state_e state;
  atd_pkg::atd_word_t  rbuf [NCH];
  atd_pkg::atd_word_t  fmt_word;
  atd_pkg::atd_word_t  result;
  logic [CW-1:0]       chan;
  logic [CW-1:0]       fifo_ptr;
  logic                upper_half;
  logic                detect_mode;
  logic                trig_hit;
  logic                cmp_hit;
  logic                eval_hit;
  logic                do_store;
  logic                last_chan;
  logic [CW-1:0]       mirror_addr;
  logic [CW-1:0]       store_addr;

  assign detect_mode = i_threshold_detect_enable
                       && i_write_disposition_field != `ATD_WR_LEGACY;
  assign trig_hit    = i_trigger[i_trigger_source_select];
  assign last_chan   = chan == last_sel(i_scan_select);
  assign mirror_addr = CW'((int'(chan) + MIRROR_OFS) % NCH);
  assign eval_hit    = detect_mode && cmp_hit;

  // With detect enabled, discard unless legacy, or compare-store with a match
  always_comb begin
    unique case (i_write_disposition_field)
      `ATD_WR_LEGACY:    do_store = 1'b1;
      `ATD_WR_CMP_STORE: do_store = !i_threshold_detect_enable || cmp_hit;
      default:           do_store = !i_threshold_detect_enable;
    endcase
  end

  // Channel indexed, else single or split FIFO
  always_comb begin
    if (i_channel_indexed_bit) begin
      store_addr = chan;
    end else if (i_split_buffer_bit) begin
      store_addr = upper_half ? CW'(int'(fifo_ptr) % HALF + HALF)
                              : CW'(int'(fifo_ptr) % HALF);
    end else begin
      store_addr = fifo_ptr;
    end
  end

  atd_formatter u_fmt (
    .i_code   (i_conv_code),
    .i_ten_bit(i_ten_bit_mode),
    .i_layout (i_result_layout_select),
    .o_word   (fmt_word)
  );

  atd_comparator u_cmp (
    .i_value   (result),
    .i_thr_lo  (rbuf[chan]),
    .i_thr_hi  (rbuf[mirror_addr]),
    .i_cmp_type(i_compare_type_field),
    .i_signed  (i_result_layout_select[0]),
    .o_hit     (cmp_hit)
  );

  // ----------------------------------------------------------------
  // Scan sequencer
  // ----------------------------------------------------------------
  // Detect or legacy both start from scan enable; rearms each trigger
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= atd_pkg::ATD_IDLE;
      chan  <= '0;
    end else begin
      unique case (state)
        atd_pkg::ATD_IDLE: begin
          if (i_scan_enable_bit && |i_scan_select) begin
            state <= atd_pkg::ATD_ARMED;
          end
        end
        atd_pkg::ATD_ARMED: begin
          if (!i_scan_enable_bit) begin
            state <= atd_pkg::ATD_IDLE;
          end else if (trig_hit) begin
            chan  <= next_sel(i_scan_select, last_sel(i_scan_select));
            state <= atd_pkg::ATD_START;
          end
        end
        atd_pkg::ATD_START: state <= atd_pkg::ATD_WAIT;
        atd_pkg::ATD_WAIT: begin
          if (i_conv_done) begin
            state <= atd_pkg::ATD_EVAL;
          end
        end
        atd_pkg::ATD_EVAL: begin
          if (last_chan) begin
            state <= atd_pkg::ATD_ARMED;
          end else begin
            chan  <= next_sel(i_scan_select, chan);
            state <= atd_pkg::ATD_START;
          end
        end
      endcase
    end
  end

  assign o_conv_start = state == atd_pkg::ATD_START;
  assign o_conv_chan  = chan;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result <= '0;
    end else if (state == atd_pkg::ATD_WAIT && i_conv_done) begin
      result <= fmt_word;
    end
  end

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  // Hardware store wins; a software write in that cycle is dropped
  always_ff @(posedge i_clk_sys) begin
    if (state == atd_pkg::ATD_EVAL && do_store) begin
      rbuf[store_addr] <= result;
    end else if (i_buf_wr) begin
      rbuf[i_buf_addr] <= i_buf_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_buf_rdata <= '0;
    end else if (i_buf_rd) begin
      o_buf_rdata <= rbuf[i_buf_addr];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fifo_ptr   <= '0;
      upper_half <= 1'b0;
    end else if (state == atd_pkg::ATD_EVAL) begin
      if (last_chan) begin
        fifo_ptr   <= '0;
        upper_half <= i_split_buffer_bit && !upper_half;
      end else if (do_store) begin
        fifo_ptr <= CW'((int'(fifo_ptr) + 1) % NCH);
      end
    end
  end

  // ----------------------------------------------------------------
  // Hits, events and power
  // ----------------------------------------------------------------
  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_compare_hit <= '0;
    end else begin
      o_compare_hit <= (o_compare_hit & ~i_hit_clear)
        | (NCH'(state == atd_pkg::ATD_EVAL && eval_hit) << chan);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_match_pulse <= 1'b0;
      o_scan_done   <= 1'b0;
    end else begin
      o_match_pulse <= state == atd_pkg::ATD_EVAL && eval_hit;
      o_scan_done   <= state == atd_pkg::ATD_EVAL && last_chan;
    end
  end

  // Sequencer runs on the system clock regardless of core sleep
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wake_request <= 1'b0;
    end else if (o_match_pulse && i_core_asleep) begin
      o_wake_request <= 1'b1;
    end else if (!i_core_asleep) begin
      o_wake_request <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sleep_return <= 1'b0;
    end else begin
      o_sleep_return <= i_int_serviced && i_low_power_threshold_enable
                        && i_threshold_detect_enable;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_hit_needs_enable: assert property (
    $rose(o_match_pulse) |-> $past(i_threshold_detect_enable))
    else $error("match without detect enable");

  a_hit_sets_bit: assert property (
    (state == atd_pkg::ATD_EVAL && eval_hit)
      |=> o_compare_hit[$past(chan)] && o_match_pulse)
    else $error("match not recorded");

  a_hit_sticky: assert property (
    &(o_compare_hit | ~$past(o_compare_hit & ~i_hit_clear)))
    else $error("hit bit lost without clear");

  a_trig_starts: assert property (
    (state == atd_pkg::ATD_ARMED && i_scan_enable_bit && trig_hit)
      |=> o_conv_start ##1 !o_conv_start)
    else $error("trigger did not start conversion");

  a_chan_selected: assert property (
    o_conv_start |-> i_scan_select[o_conv_chan])
    else $error("unselected channel converted");

  a_discard_keeps: assert property (
    (state == atd_pkg::ATD_EVAL && i_threshold_detect_enable
      && i_write_disposition_field == `ATD_WR_CMP_DISCARD) |-> !do_store)
    else $error("discard mode stored result");

  a_legacy_stores: assert property (
    (state == atd_pkg::ATD_EVAL
      && i_write_disposition_field == `ATD_WR_LEGACY) |-> do_store)
    else $error("legacy mode did not store");

  a_store_on_match: assert property (
    (state == atd_pkg::ATD_EVAL && i_threshold_detect_enable
      && i_write_disposition_field == `ATD_WR_CMP_STORE)
      |-> do_store == cmp_hit)
    else $error("compare-store mismatch");

  a_sleep_return: assert property (
    (i_int_serviced && i_low_power_threshold_enable
      && i_threshold_detect_enable) |=> o_sleep_return)
    else $error("no return to low power");

  a_wake_on_match: assert property (
    (o_match_pulse && i_core_asleep) |=> o_wake_request)
    else $error("no wake on match");

  c_match_seen: cover property (o_match_pulse);
  c_scan_done: cover property (o_scan_done ##[1:50] o_scan_done);
  c_window_hit: cover property (
    o_match_pulse && i_compare_type_field == `ATD_CMP_INSIDE);

endmodule : atd_top

// *** tb/test_adc_result_format_threshold_detect.sv ***
`timescale 1ns/1ps
`include "atd_consts.svh"

module test_adc_result_format_threshold_detect;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic               clk_sys, rst_n, detect_en, scan_en, lp_en;
  logic               split_buf, chan_idx, ten_bit, conv_done;
  logic               buf_wr, buf_rd, core_asleep, int_serviced;
  logic [3:0]         trig_sel, buf_addr, conv_chan;
  logic [1:0]         cmp_type, wr_disp, layout;
  logic [15:0]        scan_sel, trigger, hit_clear, compare_hit, rd_val, exp_w;
  logic [11:0]        conv_code, c;
  atd_pkg::atd_word_t buf_wdata, buf_rdata;
  logic               conv_start, match_pulse, scan_done;
  logic               wake_req, sleep_ret, saw_match, seen;
  int                 num_errors, checks_done, k;
  logic [11:0]        codes [8] = '{12'h000, 12'h7ff, 12'h800, 12'hfff,
                                    12'h000, 12'h1ff, 12'h200, 12'h3ff};
  // Compare table: type, code, expected hit
  logic [1:0]         ctype [9] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2,
                                    2'h3, 2'h3, 2'h3};
  logic [11:0]        ccode [9] = '{12'h080, 12'h200, 12'h200, 12'h100,
                                    12'h200, 12'h300, 12'h080, 12'h200,
                                    12'h3ff};
  logic               chit  [9] = '{1, 0, 1, 0, 1, 0, 1, 0, 1};

  atd_top dut_u (
    .i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_threshold_detect_enable(detect_en), .i_scan_enable_bit(scan_en),
    .i_trigger_source_select(trig_sel),
    .i_low_power_threshold_enable(lp_en),
    .i_compare_type_field(cmp_type), .i_write_disposition_field(wr_disp),
    .i_split_buffer_bit(split_buf), .i_channel_indexed_bit(chan_idx),
    .i_result_layout_select(layout), .i_ten_bit_mode(ten_bit),
    .i_scan_select(scan_sel), .i_trigger(trigger),
    .o_conv_start(conv_start), .o_conv_chan(conv_chan),
    .i_conv_done(conv_done), .i_conv_code(conv_code),
    .i_buf_wr(buf_wr), .i_buf_rd(buf_rd), .i_buf_addr(buf_addr),
    .i_buf_wdata(buf_wdata), .o_buf_rdata(buf_rdata),
    .i_hit_clear(hit_clear), .o_compare_hit(compare_hit),
    .o_match_pulse(match_pulse), .o_scan_done(scan_done),
    .i_core_asleep(core_asleep), .i_int_serviced(int_serviced),
    .o_wake_request(wake_req), .o_sleep_return(sleep_ret)
  );

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Match pulses last one cycle, so latch them for later checks
  always @(posedge clk_sys) begin
    if (match_pulse === 1'b1) saw_match <= 1'b1;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] got,
                       input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic buf_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    buf_wr <= 1'b1; buf_addr <= a; buf_wdata <= d;
    @(posedge clk_sys);
    buf_wr <= 1'b0;
  endtask : buf_write

  task automatic buf_read(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    buf_rd <= 1'b1; buf_addr <= a;
    @(posedge clk_sys);
    buf_rd <= 1'b0;
    #1 d = buf_rdata;
  endtask : buf_read

  task automatic clear_hits();
    @(posedge clk_sys);
    hit_clear <= 16'hffff;
    @(posedge clk_sys);
    hit_clear <= 16'h0000;
  endtask : clear_hits

  // Trigger one scan and answer each conversion request in order
  task automatic run_scan(input logic [15:0] mask, input logic [11:0] cd);
    int n;
    @(posedge clk_sys);
    scan_sel <= mask;
    saw_match = 1'b0;
    repeat (2) @(posedge clk_sys);
    trigger <= 16'h0001 << trig_sel;
    @(posedge clk_sys);
    trigger <= 16'h0000;
    for (int ch = 0; ch < 16; ch++) begin
      if (mask[ch]) begin
        n = 0;
        #1;
        while (conv_start !== 1'b1 && n < 20) begin
          @(posedge clk_sys); #1; n++;
        end
        check("start", 16'(conv_start), 16'h0001);
        check("chan", 16'(conv_chan), 16'(ch));
        repeat (2) @(posedge clk_sys);
        conv_done <= 1'b1; conv_code <= cd;
        @(posedge clk_sys);
        conv_done <= 1'b0; conv_code <= ~cd;
      end
    end
    n = 0;
    #1;
    while (scan_done !== 1'b1 && n < 20) begin
      @(posedge clk_sys); #1; n++;
    end
    check("scan done", 16'(scan_done), 16'h0001);
    repeat (3) @(posedge clk_sys);
  endtask : run_scan

  function automatic logic [15:0] fmt(input logic [11:0] v, input logic t,
                                      input logic [1:0] l);
    int          mid;
    logic [15:0] raw;
    logic [15:0] sgn;
    // Signed layouts are the code minus midscale, in two's complement
    mid = t ? 512 : 2048;
    raw = t ? {6'h00, v[9:0]} : {4'h0, v};
    sgn = 16'(int'(raw) - mid);
    case (l)
      `ATD_LAYOUT_INT:  return raw;
      `ATD_LAYOUT_SINT: return sgn;
      `ATD_LAYOUT_FRAC: return t ? raw << 6 : raw << 4;
      default:          return t ? sgn << 6 : sgn << 4;
    endcase
  endfunction : fmt

  // ----------------------------------------------------------------
  // Watchdog, far above the expected run of under 1,000 cycles
  // ----------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; detect_en = 1'b0; scan_en = 1'b0; lp_en = 1'b0;
    split_buf = 1'b0; chan_idx = 1'b1; ten_bit = 1'b0;
    conv_done = 1'b0; buf_wr = 1'b0; buf_rd = 1'b0; core_asleep = 1'b0;
    int_serviced = 1'b0; trig_sel = 4'h0; buf_addr = 4'h0;
    cmp_type = 2'h0; wr_disp = `ATD_WR_LEGACY; layout = 2'h0;
    scan_sel = 16'h0000; trigger = 16'h0000; hit_clear = 16'h0000;
    conv_code = 12'h000; buf_wdata = 16'h0000; saw_match = 1'b0;
    num_errors = 0; checks_done = 0; k = 0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1 check("hits after reset", compare_hit, 16'h0000);
    // Every layout and width, detect off, each trigger source in turn
    @(posedge clk_sys);
    scan_en <= 1'b1;
    for (int t = 0; t < 2; t++) begin
      for (int l = 0; l < 4; l++) begin
        for (int i = 0; i < 4; i++) begin
          @(posedge clk_sys);
          ten_bit <= t[0]; layout <= l[1:0]; trig_sel <= k[3:0];
          k++;
          c = codes[t * 4 + i];
          run_scan(16'h0001, c);
          buf_read(4'h0, rd_val);
          exp_w = fmt(c, t[0], l[1:0]);
          check("format", rd_val, exp_w);
        end
      end
    end
    // Wrong trigger bit, then scan disabled: no conversion may start
    @(posedge clk_sys);
    ten_bit <= 1'b0; layout <= `ATD_LAYOUT_INT; trig_sel <= 4'h5;
    seen = 1'b0;
    repeat (2) @(posedge clk_sys);
    trigger <= 16'h0008;
    // Sample every cycle, from the wrong bit through the disabled phase
    for (int n = 0; n < 12; n++) begin
      @(posedge clk_sys);
      if (n == 3) begin
        trigger <= 16'h0000;
        scan_en <= 1'b0; detect_en <= 1'b1;
      end
      if (n == 5) trigger <= 16'h0020;
      if (n == 11) trigger <= 16'h0000;
      #1 seen = seen | (conv_start !== 1'b0);
    end
    check("idle start", 16'(seen), 16'h0000);
    // Ascending scan of three channels, channel-indexed storage
    @(posedge clk_sys);
    scan_en <= 1'b1; detect_en <= 1'b0;
    run_scan(16'h8022, 12'h123);
    buf_read(4'h5, rd_val);
    check("indexed store", rd_val, 16'h0123);
    // Each compare type, compare then discard
    @(posedge clk_sys);
    detect_en <= 1'b1; wr_disp <= `ATD_WR_CMP_DISCARD;
    for (int i = 0; i < 9; i++) begin
      buf_write(4'h2, 16'h0100);
      buf_write(4'hb, 16'h0300);
      clear_hits();
      @(posedge clk_sys);
      cmp_type <= ctype[i];
      run_scan(16'h0004, ccode[i]);
      check("hit", compare_hit, 16'(chit[i]) << 2);
      check("match", 16'(saw_match), 16'(chit[i]));
      buf_read(4'h2, rd_val);
      check("kept threshold", rd_val, 16'h0100);
    end
    // Compare and store: stored only on a match, hits sticky
    @(posedge clk_sys);
    wr_disp <= `ATD_WR_CMP_STORE; cmp_type <= `ATD_CMP_GREATER;
    clear_hits();
    run_scan(16'h0004, 12'h080);
    buf_read(4'h2, rd_val);
    check("no store", rd_val, 16'h0100);
    run_scan(16'h0004, 12'h200);
    buf_read(4'h2, rd_val);
    check("stored", rd_val, 16'h0200);
    run_scan(16'h0004, 12'h080);
    check("sticky hit", compare_hit, 16'h0004);
    clear_hits();
    #1 check("cleared hit", compare_hit, 16'h0000);
    // Detect off: plain store, no comparison at all
    @(posedge clk_sys);
    detect_en <= 1'b0;
    buf_write(4'h2, 16'h0100);
    run_scan(16'h0004, 12'h200);
    check("hit disabled", compare_hit, 16'h0000);
    check("match disabled", 16'(saw_match), 16'h0000);
    buf_read(4'h2, rd_val);
    check("store disabled", rd_val, 16'h0200);
    // Low power: wake on match, return after service
    @(posedge clk_sys);
    detect_en <= 1'b1; wr_disp <= `ATD_WR_CMP_DISCARD;
    core_asleep <= 1'b1; lp_en <= 1'b1;
    buf_write(4'h2, 16'h0100);
    run_scan(16'h0004, 12'h200);
    check("wake", 16'(wake_req), 16'h0001);
    core_asleep <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1 check("wake cleared", 16'(wake_req), 16'h0000);
    @(posedge clk_sys);
    int_serviced <= 1'b1;
    @(posedge clk_sys);
    int_serviced <= 1'b0;
    #1 check("sleep return", 16'(sleep_ret), 16'h0001);
    @(posedge clk_sys);
    lp_en <= 1'b0;
    int_serviced <= 1'b1;
    @(posedge clk_sys);
    int_serviced <= 1'b0;
    #1 check("no sleep return", 16'(sleep_ret), 16'h0000);
    // FIFO storage, then split halves alternating per scan
    @(posedge clk_sys);
    detect_en <= 1'b0; wr_disp <= `ATD_WR_LEGACY; chan_idx <= 1'b0;
    run_scan(16'h8022, 12'h456);
    buf_read(4'h2, rd_val);
    check("fifo store", rd_val, 16'h0456);
    @(posedge clk_sys);
    split_buf <= 1'b1;
    run_scan(16'h8022, 12'h789);
    run_scan(16'h8022, 12'h0ab);
    buf_read(4'ha, rd_val);
    check("upper half", rd_val, 16'h00ab);
    buf_read(4'h2, rd_val);
    check("lower half", rd_val, 16'h0789);
    // Signed layout compares as two's complement, not unsigned
    @(posedge clk_sys);
    detect_en <= 1'b1; wr_disp <= `ATD_WR_CMP_DISCARD;
    split_buf <= 1'b0; chan_idx <= 1'b1; layout <= `ATD_LAYOUT_SINT;
    buf_write(4'h2, 16'hff00);
    clear_hits();
    run_scan(16'h0004, 12'h800);
    check("signed hit", compare_hit, 16'h0004);
    finish_test();
  end
endmodule : test_adc_result_format_threshold_detect
